// ===== trace_pkg.sv
// constants for the trace trigger and capture fifo block
package trace_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_TRACE_CTRL = 8'h00; // trace_control_register
  localparam logic [7:0] OFF_TRIG_CTRL = 8'h04; // trigger_control_register
  localparam logic [7:0] OFF_STATUS = 8'h08; // trace_status_register
  localparam logic [7:0] OFF_CMP_A = 8'h0c; // comparator a value
  localparam logic [7:0] OFF_CMP_B = 8'h10; // comparator b value
  localparam logic [7:0] OFF_CMP_C = 8'h14; // comparator c value
  localparam logic [7:0] OFF_FIFO = 8'h18; // capture fifo read port

  // trace_control_register fields
  localparam int CTRL_ENABLE_BIT = 7; // module enable
  localparam int CTRL_ARM_BIT = 6; // arm control bit
  localparam int CTRL_TAG_BIT = 5; // tag-type break select
  localparam int CTRL_CPU_BREAK_ENABLE_BIT = 4; // cpu_break_enable

  // trigger_control_register fields
  localparam int TRIG_QUAL_BIT = 7; // opcode_qualify_select
  localparam int TRIG_BEGIN_BIT = 6; // begin-type run select
  localparam int TRIG_MODE_MSB = 3; // trigger mode field top bit

  // trace_status_register fields
  localparam int STAT_A_BIT = 7; // comparator_a_match_flag
  localparam int STAT_B_BIT = 6; // comparator_b_match_flag
  localparam int STAT_C_BIT = 5; // comparator_c_match_flag
  localparam int STAT_ARMED_BIT = 4; // armed_status_flag

  // trigger mode encodings
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_AND_B = 4'h2;
  localparam logic [3:0] MODE_A_AND_NOT_B = 4'h3;
  localparam logic [3:0] MODE_EVENT_B = 4'h4;
  localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h5;
  localparam logic [3:0] MODE_INSIDE = 4'h6;
  localparam logic [3:0] MODE_OUTSIDE = 4'h7;
  localparam logic [3:0] MODE_A_THEN_B = 4'h8;

  // fifo shape and capture arithmetic
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
  localparam logic [15:0] BRANCH_SRC_ADJUST = 16'h0002;
  localparam logic [7:0] EVENT_HIGH_BYTE = 8'h00;

  // reset values
  localparam logic [7:0] TRACE_CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;

endpackage : trace_pkg

// ===== trace_trigger.sv
// trace trigger logic, run control and eight word capture fifo behind an apb slave

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - a-only mode sets a flag on a match
// - a-or-b sets each matching comparator flag
// - a-then-b compares b only after a
// - event-only-b sets b flag, always begin-type
// - a-then-event-b: b after a, begin-type
// - a-and-b: both flags on same-cycle match
// - full modes, tag end run: break on a
// - a-and-not-b: a match, b miss, both flags
// - inside range inclusive sets both flags
// - outside range: below a, above b
// - two bits, begin and tag, choose run type and break
// - break enable clear means no break request
// - eight deep fifo, addresses or event data
// - event words read zero upper byte
// - destination flow change stores current address
// - taken branch stores previous address minus two
// - begin run stores from the trigger cycle until eight
// - end run stops and disarms at trigger
// - event-only modes never use end storage
// - end trigger on flow change still stored
// - a-only is code zero, a-or-b one
// - arming clears a, b and c flags
// - qualify uses executed opcode address match
// - end run drops oldest entry when full
module trace_trigger
  import trace_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // cpu core buses and indicators
  input wire logic bus_valid_in,
  input wire logic [15:0] core_addr_in,
  input wire logic [7:0] core_data_in,
  input wire logic [1:0] core_cof_in,
  input wire logic exec_valid_in,
  input wire logic [15:0] exec_addr_in,
  // cpu break request and visible state
  output logic cpu_break_out,
  output logic cpu_break_tag_out,
  output logic armed_out
);

  //////////////////////////////////////////////////////////////////////////////
  // state record

  typedef struct packed {
    logic [7:0] ctrl; // trace_control_register
    logic [7:0] trig; // trigger_control_register
    logic [15:0] cmp_a; // comparator a value
    logic [15:0] cmp_b; // comparator b value
    logic [15:0] cmp_c; // comparator c value
    logic flag_a; // comparator_a_match_flag
    logic flag_b; // comparator_b_match_flag
    logic flag_c; // comparator_c_match_flag
    logic armed; // armed_status_flag
    logic started; // begin run has seen its trigger
    logic a_seen; // a matched in the sequential modes
    logic [15:0] prev_addr; // address of the previous bus cycle
    logic [FIFO_DEPTH-1:0][15:0] fifo; // capture words, index 0 is oldest
    logic [3:0] count; // valid words held
    logic [2:0] rd_idx; // next word handed to the reader
    logic brk; // one-cycle break request
    logic [31:0] rdata; // read data latched in the setup cycle
    logic slverr; // unmapped address seen in the setup cycle
  } state_t;

  state_t q_r; // registered state
  state_t q_nxt; // next state

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the apb address is one of ours
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFF_TRACE_CTRL) || (a == OFF_TRIG_CTRL) || (a == OFF_STATUS) ||
                  (a == OFF_CMP_A) || (a == OFF_CMP_B) || (a == OFF_CMP_C) ||
                  (a == OFF_FIFO);
  endfunction : addr_mapped

  // shift the fifo toward the oldest slot, dropping entry 0
  function automatic logic [FIFO_DEPTH-1:0][15:0] fifo_shift(
    input logic [FIFO_DEPTH-1:0][15:0] f, input logic [15:0] w);
    logic [FIFO_DEPTH-1:0][15:0] r;
    r = f;
    for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
      r[i] = f[i+1];
    end
    r[FIFO_DEPTH-1] = w;
    fifo_shift = r;
  endfunction : fifo_shift

  //////////////////////////////////////////////////////////////////////////////
  // comparator decode

  logic enable; // module enabled
  logic [3:0] mode; // trigger mode field
  logic event_only; // one of the event-only modes
  logic begin_run; // run behaves as begin-type
  logic qual; // opcode qualification in force
  logic full_mode; // address-and-data modes
  logic tag_sel; // tag-type breaks chosen
  logic brk_en; // cpu_break_enable
  logic cmp_ok; // a compare is valid this cycle
  logic [15:0] cmp_addr; // address the comparators look at
  logic ma; // comparator a address match
  logic mb; // comparator b address match
  logic mb_data; // comparator b data bus match
  logic hit_a; // sets comparator_a_match_flag
  logic hit_b; // sets comparator_b_match_flag
  logic trigger; // trigger condition met
  logic [15:0] cof_word; // change of flow word to store
  logic [15:0] event_word; // event data word to store

  // mode flags and the matches of each comparator
  always_comb begin
    enable = q_r.ctrl[CTRL_ENABLE_BIT];
    mode = q_r.trig[TRIG_MODE_MSB:0];
    event_only = (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
    begin_run = q_r.trig[TRIG_BEGIN_BIT] | event_only;
    qual = q_r.trig[TRIG_QUAL_BIT] & ~event_only;
    full_mode = (mode == MODE_A_AND_B) || (mode == MODE_A_AND_NOT_B);
    tag_sel = q_r.ctrl[CTRL_TAG_BIT];
    brk_en = q_r.ctrl[CTRL_CPU_BREAK_ENABLE_BIT];
    // qualified compares look at the opcode about to execute
    cmp_addr = qual ? exec_addr_in : core_addr_in;
    cmp_ok = qual ? exec_valid_in : bus_valid_in;
    ma = cmp_ok && (cmp_addr == q_r.cmp_a);
    mb = cmp_ok && (cmp_addr == q_r.cmp_b);
    mb_data = bus_valid_in && (core_data_in == q_r.cmp_b[7:0]);
    cof_word = core_cof_in[1] ? core_addr_in : q_r.prev_addr - BRANCH_SRC_ADJUST;
    event_word = {EVENT_HIGH_BYTE, core_data_in};
    hit_a = 1'b0;
    hit_b = 1'b0;
    trigger = 1'b0;
    case (mode)
      MODE_A_ONLY: begin
        hit_a = ma;
        trigger = ma;
      end
      MODE_A_OR_B: begin
        hit_a = ma;
        hit_b = mb;
        trigger = ma | mb;
      end
      MODE_A_THEN_B: begin
        hit_a = ma;
        hit_b = q_r.a_seen & mb;
        trigger = hit_b;
      end
      MODE_EVENT_B: begin
        hit_b = bus_valid_in && (core_addr_in == q_r.cmp_b);
        trigger = hit_b;
      end
      MODE_A_THEN_EVENT_B: begin
        hit_a = ma;
        hit_b = q_r.a_seen && bus_valid_in && (core_addr_in == q_r.cmp_b);
        trigger = hit_b;
      end
      MODE_A_AND_B: begin
        hit_a = ma & mb_data;
        hit_b = ma & mb_data;
        trigger = ma & mb_data;
      end
      MODE_A_AND_NOT_B: begin
        hit_a = ma & ~mb_data;
        hit_b = ma & ~mb_data;
        trigger = ma & ~mb_data;
      end
      MODE_INSIDE: begin
        hit_a = cmp_ok && (cmp_addr >= q_r.cmp_a) && (cmp_addr <= q_r.cmp_b);
        hit_b = hit_a;
        trigger = hit_a;
      end
      MODE_OUTSIDE: begin
        hit_a = cmp_ok && (cmp_addr < q_r.cmp_a);
        hit_b = cmp_ok && (cmp_addr > q_r.cmp_b);
        trigger = hit_a | hit_b;
      end
      default: begin
        trigger = 1'b0; // unused codes never trigger
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic push; // a word goes into the fifo this cycle
  logic [15:0] push_word; // the word pushed
  logic brk_cond; // end run break condition
  logic filled; // begin run has reached eight words
  logic setup; // apb setup cycle
  logic access; // apb access cycle, taken at this edge
  logic [31:0] rd_value; // read value for the current address

  // capture, run control and register access
  always_comb begin
    q_nxt = q_r;
    q_nxt.brk = 1'b0;
    push = 1'b0;
    push_word = cof_word;
    filled = 1'b0;
    setup = psel_in & ~penable_in;
    access = psel_in & penable_in;
    // tag breaks in full modes follow comparator a alone
    brk_cond = (full_mode && tag_sel && !begin_run) ? ma : trigger;
    // address of each bus cycle kept for branch sources
    if (bus_valid_in) begin
      q_nxt.prev_addr = core_addr_in;
    end
    if (q_r.armed) begin
      // sticky match flags, set only while armed; arming below happens only while disarmed
      q_nxt.flag_a = q_r.flag_a | hit_a;
      q_nxt.flag_b = q_r.flag_b | hit_b;
      q_nxt.flag_c = q_r.flag_c | (bus_valid_in && (core_addr_in == q_r.cmp_c));
      if (ma) begin
        q_nxt.a_seen = 1'b1;
      end
      if (event_only) begin
        push = hit_b;
        push_word = event_word;
      end else if (begin_run) begin
        push = (core_cof_in != 2'b00) && (q_r.started || trigger);
      end else begin
        push = (core_cof_in != 2'b00);
      end
      if (begin_run && trigger) begin
        q_nxt.started = 1'b1;
      end
      // store the word, or drop the oldest in an end run
      if (push) begin
        if (q_r.count < FIFO_FULL_COUNT) begin
          q_nxt.fifo[q_r.count[2:0]] = push_word;
          q_nxt.count = q_r.count + 4'h1;
          filled = begin_run && (q_r.count == FIFO_FULL_COUNT - 4'h1);
        end else if (!begin_run) begin
          q_nxt.fifo = fifo_shift(q_r.fifo, push_word);
        end
      end
      // begin run ends when eight words are in
      if (filled) begin
        q_nxt.armed = 1'b0;
        q_nxt.ctrl[CTRL_ARM_BIT] = 1'b0;
        q_nxt.brk = brk_en;
      end
      // end run ends at the trigger
      if (!begin_run && trigger) begin
        q_nxt.armed = 1'b0;
        q_nxt.ctrl[CTRL_ARM_BIT] = 1'b0;
      end
      if (!begin_run && brk_cond) begin
        q_nxt.brk = brk_en;
      end
    end
    // read value of the addressed register
    case (paddr_in)
      OFF_TRACE_CTRL: rd_value = {24'h000000, q_r.ctrl};
      OFF_TRIG_CTRL: rd_value = {24'h000000, q_r.trig};
      OFF_STATUS: rd_value = {24'h000000, q_r.flag_a, q_r.flag_b, q_r.flag_c, q_r.armed,
                              q_r.count};
      OFF_CMP_A: rd_value = {16'h0000, q_r.cmp_a};
      OFF_CMP_B: rd_value = {16'h0000, q_r.cmp_b};
      OFF_CMP_C: rd_value = {16'h0000, q_r.cmp_c};
      OFF_FIFO: rd_value = {16'h0000, q_r.fifo[q_r.rd_idx]};
      default: rd_value = 32'h00000000;
    endcase
    // setup cycle latches the answer given in the access cycle
    if (setup) begin
      q_nxt.rdata = pwrite_in ? 32'h00000000 : rd_value;
      q_nxt.slverr = ~addr_mapped(paddr_in);
    end
    // fifo read advances only while disarmed; the count stays
    if (access && !pwrite_in && (paddr_in == OFF_FIFO) && !q_r.armed) begin
      q_nxt.rd_idx = q_r.rd_idx + 3'h1;
    end
    // register writes
    if (access && pwrite_in) begin
      case (paddr_in)
        OFF_TRACE_CTRL: begin
          q_nxt.ctrl = pwdata_in[7:0];
          if (!pwdata_in[CTRL_ARM_BIT]) begin
            q_nxt.armed = 1'b0; // disarm by writing arm low
          end else if (pwdata_in[CTRL_ENABLE_BIT] && !q_r.armed) begin
            // arming starts a fresh run
            q_nxt.armed = 1'b1;
            q_nxt.flag_a = 1'b0;
            q_nxt.flag_b = 1'b0;
            q_nxt.flag_c = 1'b0;
            q_nxt.started = 1'b0;
            q_nxt.a_seen = 1'b0;
            q_nxt.count = 4'h0;
            q_nxt.rd_idx = 3'h0;
          end
        end
        OFF_TRIG_CTRL: q_nxt.trig = pwdata_in[7:0];
        OFF_CMP_A: q_nxt.cmp_a = pwdata_in[15:0];
        OFF_CMP_B: q_nxt.cmp_b = pwdata_in[15:0];
        OFF_CMP_C: q_nxt.cmp_c = pwdata_in[15:0];
        default: begin
          q_nxt.slverr = q_r.slverr; // read-only or unmapped: no change
        end
      endcase
    end
    // a disabled module is never armed
    if (!q_nxt.ctrl[CTRL_ENABLE_BIT] || !enable && !q_nxt.armed) begin
      q_nxt.armed = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // every bit of state resets to a constant
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q_r <= '0;
      q_r.ctrl <= TRACE_CTRL_RST;
      q_r.trig <= TRIG_CTRL_RST;
      q_r.cmp_a <= CMP_RST;
      q_r.cmp_b <= CMP_RST;
      q_r.cmp_c <= CMP_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // apb answers with no wait state
  assign pready_out = 1'b1;
  assign prdata_out = q_r.rdata;
  assign pslverr_out = q_r.slverr;

  // break request and its kind
  assign cpu_break_out = q_r.brk;
  assign cpu_break_tag_out = q_r.ctrl[CTRL_TAG_BIT] & q_r.ctrl[CTRL_CPU_BREAK_ENABLE_BIT];
  assign armed_out = q_r.armed;

endmodule : trace_trigger

// ===== trace_trigger_assertions.sv
// port assertions for the trace trigger block
module trace_trigger_assertions
  import trace_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb side
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // break and arm state
  input wire logic cpu_break_out,
  input wire logic cpu_break_tag_out,
  input wire logic armed_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc; // apb access cycle
  logic mapped; // address hits a register
  logic ctrl_wr; // trace control write
  logic arm_wr; // written value enables and arms
  logic [7:0] ctrl_r; // software copy of trace control
  assign acc = psel_in & penable_in;
  assign mapped = paddr_in inside {OFF_TRACE_CTRL, OFF_TRIG_CTRL, OFF_STATUS, OFF_CMP_A,
    OFF_CMP_B, OFF_CMP_C, OFF_FIFO};
  assign ctrl_wr = acc & pwrite_in & (paddr_in == OFF_TRACE_CTRL);
  assign arm_wr = pwdata_in[CTRL_ENABLE_BIT] & pwdata_in[CTRL_ARM_BIT];
  // copy follows writes only, so break enable and tag track software
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) ctrl_r <= TRACE_CTRL_RST;
    else if (ctrl_wr) ctrl_r <= pwdata_in[7:0];
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_break_needs_en: assert property (cpu_break_out |-> $past(ctrl_r[CTRL_CPU_BREAK_ENABLE_BIT]))
    else $error("break without break enable");
  a_break_while_armed: assert property (cpu_break_out |-> $past(armed_out))
    else $error("break while not armed");
  a_force_disarms: assert property (cpu_break_out && !$past(ctrl_r[CTRL_TAG_BIT]) |-> !armed_out)
    else $error("force break left block armed");
  a_arm_sets: assert property (ctrl_wr && arm_wr && !armed_out |=> armed_out)
    else $error("arming write did not arm");
  a_disarm_clears: assert property (ctrl_wr && !arm_wr |=> !armed_out)
    else $error("disarming write left block armed");
  a_status_armed: assert property (acc && !pwrite_in && paddr_in == OFF_STATUS
    |-> prdata_out[STAT_ARMED_BIT] == $past(armed_out))
    else $error("status armed bit differs");
  a_err_unmapped: assert property (acc |-> pslverr_out == !mapped)
    else $error("slave error wrong");
  a_tag_needs_en: assert property (cpu_break_tag_out == (ctrl_r[CTRL_TAG_BIT] & ctrl_r[CTRL_CPU_BREAK_ENABLE_BIT]))
    else $error("tag kind shown without break enable");
  a_ready_high: assert property (pready_out)
    else $error("ready low");
  a_read_upper: assert property (acc && !pwrite_in |-> prdata_out[31:16] == 16'h0000)
    else $error("read upper half not zero");
endmodule : trace_trigger_assertions

// ===== cpu_core_model.sv
// behavioural cpu core driving the bus and flow indicators
module cpu_core_model (
  // clock
  input wire logic clk_in,
  // core buses and indicators
  output logic bus_valid_out,
  output logic [15:0] core_addr_out,
  output logic [7:0] core_data_out,
  output logic [1:0] core_cof_out,
  output logic exec_valid_out,
  output logic [15:0] exec_addr_out,
  // break request back from the trace block
  input wire logic cpu_break_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int break_count; // break pulses seen
  // idle bus at time zero; no opcode tracking is reported
  initial begin
    bus_valid_out = 1'b0;
    core_addr_out = 16'h0000;
    core_data_out = 8'h00;
    core_cof_out = 2'b00;
    exec_valid_out = 1'b0;
    exec_addr_out = 16'h0000;
    break_count = 0;
  end
  ////////////////////////////////////////////////////////////////
  // count break pulses
  always @(posedge clk_in) begin
    if (cpu_break_in === 1'b1) break_count++;
  end
  // one bus cycle with a flow indicator, then the bus is released
  task bus_cycle(input logic [15:0] a, input logic [7:0] d, input logic [1:0] cof);
    @(posedge clk_in);
    bus_valid_out <= 1'b1;
    core_addr_out <= a;
    core_data_out <= d;
    core_cof_out <= cof;
    @(posedge clk_in);
    bus_valid_out <= 1'b0;
    core_cof_out <= 2'b00;
    core_addr_out <= ~a; // released bus shows the inverse
    core_data_out <= ~d;
  endtask : bus_cycle
  // one opcode about to execute, reported by opcode tracking, then idle
  task exec_cycle(input logic [15:0] a);
    @(posedge clk_in);
    exec_valid_out <= 1'b1;
    exec_addr_out <= a;
    @(posedge clk_in);
    exec_valid_out <= 1'b0;
    exec_addr_out <= ~a;
  endtask : exec_cycle
endmodule : cpu_core_model

// ===== trace_trigger_and_capture_fifo_bench.sv
// self-checking bench for the trace trigger and capture fifo
module trace_trigger_and_capture_fifo_bench
  import trace_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // control words: enable and arm, plus break enable or tag
  // force breaks only with qualify clear, tag breaks never in begin runs
  localparam logic [31:0] RUN_BRK = 32'((1 << CTRL_ENABLE_BIT) | (1 << CTRL_ARM_BIT) | (1 << CTRL_CPU_BREAK_ENABLE_BIT));
  localparam logic [31:0] RUN_TAG = 32'((1 << CTRL_ENABLE_BIT) | (1 << CTRL_ARM_BIT) | (1 << CTRL_TAG_BIT));
  logic clk_in = 1'b0, sys_rst_in = 1'b1; // clock and reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
  logic [7:0] paddr = 8'h00; // apb address
  logic [31:0] pwdata = 32'h0, prdata, rd; // apb data and last read
  logic pready, pslverr, bus_valid, exec_valid, cpu_break, armed; // strobes
  logic [15:0] core_addr, exec_addr, prev_addr; // addresses
  logic [7:0] core_data, d; // data bytes
  logic [1:0] core_cof; // flow indicators
  int fail_count = 0, cmp_count = 0; // counters
  logic [31:0] exp_q[$]; // fifo model
  // flag cases: mode, address, data, expected a and b flags
  logic [3:0] md [11] = '{MODE_A_ONLY, MODE_A_OR_B, MODE_A_AND_B, MODE_A_AND_B, MODE_A_AND_NOT_B,
    MODE_A_AND_NOT_B, MODE_INSIDE, MODE_INSIDE, MODE_OUTSIDE, MODE_OUTSIDE, MODE_A_THEN_B};
  logic [15:0] ad [11] = '{16'h1000, 16'h2055, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h2055,
    16'h3000, 16'h0800, 16'h3000, 16'h2055};
  logic [7:0] dt [11] = '{8'h00, 8'h00, 8'h55, 8'h11, 8'h11, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [1:0] ef [11] = '{2'b10, 2'b01, 2'b11, 2'b00, 2'b11, 2'b00, 2'b11, 2'b00, 2'b10, 2'b01, 2'b00};
  ////////////////////////////////////////////////////////////////
  trace_trigger u_trace_trigger (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .bus_valid_in(bus_valid),
    .core_addr_in(core_addr), .core_data_in(core_data), .core_cof_in(core_cof),
    .exec_valid_in(exec_valid), .exec_addr_in(exec_addr), .cpu_break_out(cpu_break),
    .cpu_break_tag_out(), .armed_out(armed)
  );
  cpu_core_model u_cpu_core_model (
    .clk_in(clk_in), .bus_valid_out(bus_valid), .core_addr_out(core_addr),
    .core_data_out(core_data), .core_cof_out(core_cof), .exec_valid_out(exec_valid),
    .exec_addr_out(exec_addr), .cpu_break_in(cpu_break)
  );
  always #20 clk_in = ~clk_in; // 25 mhz
  // watchdog cuts a hang short
  initial begin
    #2_000_000;
    fail_count++;
    print_verdict();
  end
  // compare and count
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one apb transfer, held until ready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read status: a flag, b flag, armed
  task stat(input logic fa, input logic fb, input logic fm);
    apb(1'b0, OFF_STATUS, 32'h0, rd);
    check("status", 32'({rd[STAT_A_BIT], rd[STAT_B_BIT], rd[STAT_ARMED_BIT]}), 32'({fa, fb, fm}));
  endtask : stat
  // read the whole fifo against the model
  task drain();
    repeat (FIFO_DEPTH) begin
      apb(1'b0, OFF_FIFO, 32'h0, rd);
      check("fifo", rd, exp_q.pop_front());
    end
  endtask : drain
  // one flow change and the word it should leave in the fifo
  task cof_ev(input logic [15:0] ca, input logic [1:0] c);
    u_cpu_core_model.bus_cycle(ca, 8'h00, c);
    if (c[1]) exp_q.push_back({16'h0, ca});
    else exp_q.push_back({16'h0, prev_addr - 16'h0002});
    if (exp_q.size() > FIFO_DEPTH) void'(exp_q.pop_front());
    prev_addr = ca;
  endtask : cof_ev
  // counts, verdict and end of run
  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    void'($urandom(32'h633b));
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // control, trigger, status and comparator a read zero, as does a hole
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, rd);
      check("reset_read", rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
    // end run, a only, force break: fifo keeps the last eight flow changes
    apb(1'b1, OFF_CMP_A, 32'h4000, rd);
    apb(1'b1, OFF_TRIG_CTRL, {28'h0, MODE_A_ONLY}, rd);
    apb(1'b1, OFF_TRACE_CTRL, RUN_BRK, rd);
    prev_addr = 16'h0200;
    u_cpu_core_model.bus_cycle(prev_addr, 8'h00, 2'b00);
    repeat (11) cof_ev({2'b00, 14'($urandom)}, 2'($urandom_range(1, 2)));
    cof_ev(16'h4000, 2'b10);
    repeat (3) @(posedge clk_in);
    check("breaks", 32'(u_cpu_core_model.break_count), 32'd1);
    stat(1'b1, 1'b0, 1'b0);
    check("count", 32'(rd[3:0]), 32'(FIFO_FULL_COUNT));
    drain();
    $display("test end_run done");
    // event b with begin bit clear still runs begin type until eight events
    apb(1'b1, OFF_CMP_B, 32'h5000, rd);
    apb(1'b1, OFF_TRIG_CTRL, {28'h0, MODE_EVENT_B}, rd);
    apb(1'b1, OFF_TRACE_CTRL, RUN_BRK, rd);
    u_cpu_core_model.bus_cycle(16'h5001, 8'h33, 2'b10);
    repeat (FIFO_DEPTH) begin
      d = 8'($urandom);
      u_cpu_core_model.bus_cycle(16'h5000, d, 2'b00);
      exp_q.push_back({16'h0, EVENT_HIGH_BYTE, d});
    end
    repeat (3) @(posedge clk_in);
    check("breaks", 32'(u_cpu_core_model.break_count), 32'd2);
    stat(1'b0, 1'b1, 1'b0);
    drain();
    $display("test event_run done");
    // flag cases with break disabled and tag set: no break may follow
    apb(1'b1, OFF_CMP_A, 32'h1000, rd);
    apb(1'b1, OFF_CMP_B, 32'h2055, rd);
    foreach (md[i]) begin
      apb(1'b1, OFF_TRIG_CTRL, {28'h0, md[i]}, rd);
      apb(1'b1, OFF_TRACE_CTRL, RUN_TAG, rd);
      stat(1'b0, 1'b0, 1'b1);
      u_cpu_core_model.bus_cycle(ad[i], dt[i], 2'b00);
      stat(ef[i][1], ef[i][0], ef[i] == 2'b00);
    end
    check("no_break", 32'(u_cpu_core_model.break_count), 32'd2);
    $display("test flag_modes done");
    // qualified full mode, tag end run: bus address alone no match, executed a breaks
    apb(1'b1, OFF_TRIG_CTRL, 32'((1 << TRIG_QUAL_BIT) | MODE_A_AND_B), rd);
    apb(1'b1, OFF_TRACE_CTRL, RUN_BRK | RUN_TAG, rd);
    u_cpu_core_model.bus_cycle(16'h1000, 8'h11, 2'b00);
    repeat (3) @(posedge clk_in);
    check("qual_bus", 32'(u_cpu_core_model.break_count), 32'd2);
    u_cpu_core_model.exec_cycle(16'h1000);
    repeat (3) @(posedge clk_in);
    check("tag_break", 32'(u_cpu_core_model.break_count), 32'd3);
    stat(1'b0, 1'b0, 1'b1);
    $display("test qual_tag done");
    // a then event b ignores begin bit: b before a not stored, break at eight
    apb(1'b1, OFF_TRACE_CTRL, 32'h0, rd);
    apb(1'b1, OFF_TRIG_CTRL, {28'h0, MODE_A_THEN_EVENT_B}, rd);
    apb(1'b1, OFF_TRACE_CTRL, RUN_BRK, rd);
    u_cpu_core_model.bus_cycle(16'h2055, 8'h77, 2'b00);
    u_cpu_core_model.bus_cycle(16'h1000, 8'h00, 2'b00);
    repeat (FIFO_DEPTH) begin
      d = 8'($urandom);
      u_cpu_core_model.bus_cycle(16'h2055, d, 2'b00);
      exp_q.push_back({16'h0, EVENT_HIGH_BYTE, d});
    end
    repeat (3) @(posedge clk_in);
    check("breaks", 32'(u_cpu_core_model.break_count), 32'd4);
    stat(1'b1, 1'b1, 1'b0);
    drain();
    $display("test a_then_event done");
    print_verdict();
  end
endmodule : trace_trigger_and_capture_fifo_bench
bind trace_trigger trace_trigger_assertions u_trace_trigger_assertions (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .cpu_break_out(cpu_break_out),
  .cpu_break_tag_out(cpu_break_tag_out), .armed_out(armed_out)
);
